// file: src/acc_ctl_if.sv
`timescale 1ns/100ps
interface acc_ctl_if #(
  parameter int SYNC_WIDTH = 17
);
  logic                  run;
  logic [2:0]            divSel;
  logic                  tick;
  logic [SYNC_WIDTH-1:0] rawIn;
  logic [SYNC_WIDTH-1:0] syncOut;

  modport pre  (input run, input divSel, output tick);
  modport sync (input rawIn, output syncOut);
  modport ctl  (output run, output divSel, output rawIn, input tick, input syncOut);
endinterface

// file: src/acc_pkg.sv
package acc_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [7:0] IDX_RESULT_LOW  = 8'h78;
  localparam logic [7:0] IDX_RESULT_HIGH = 8'h79;
  localparam logic [7:0] IDX_CTRL_STATUS = 8'h7a;
  localparam logic [7:0] IDX_TRIG_CTRL   = 8'h7b;
  localparam logic [7:0] IDX_INPUT_REF   = 8'h7c;

  // Field positions in input_reference_select
  localparam int REF_SEL_LSB    = 6;
  localparam int LEFT_ALIGN_BIT = 5;
  localparam int CHAN_SEL_LSB   = 0;

  // Field positions in converter_control_status
  localparam int ENABLE_BIT     = 7;
  localparam int START_BIT      = 6;
  localparam int AUTO_TRIG_BIT  = 5;
  localparam int DONE_FLAG_BIT  = 4;
  localparam int IRQ_EN_BIT     = 3;
  localparam int DIV_SEL_LSB    = 0;

  // Field position in trigger_control_register
  localparam int TRIG_SRC_LSB   = 0;

  // Values after reset
  localparam logic [7:0] INPUT_REF_RESET   = 8'h00;
  localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
  localparam logic [7:0] TRIG_CTRL_RESET   = 8'h00;

  // Conversion lengths in converter clock cycles
  localparam logic [4:0] FIRST_CONV_CYCLES  = 5'h19;
  localparam logic [4:0] NORMAL_CONV_CYCLES = 5'h0d;

  // Trigger source code for free-running operation
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;

  // Number of external trigger sources and result width
  localparam int TRIG_COUNT   = 7;
  localparam int RESULT_WIDTH = 10;

  typedef enum logic [0:0] {
    ACC_IDLE,
    ACC_CONV
  } acc_state_e;

endpackage

// file: src/acc_prescaler.sv
`timescale 1ns/100ps
module acc_prescaler (
  input  wire logic sys_clk,
  input  wire logic reset,
  acc_ctl_if.pre    ctl
);
  logic [6:0] count_reg;
  logic [6:0] count_next;
  logic       tick_reg;
  logic       tick_next;
  logic [6:0] limit;

  // Divide by 2 for codes 0 and 1, else by two to the code
  always_comb begin
    limit      = (ctl.divSel < 3'h2) ? 7'h01 : 7'((8'h01 << ctl.divSel) - 8'h01);
    count_next = 7'h00;
    tick_next  = 1'b0;
    if (ctl.run) begin
      if (count_reg >= limit) begin
        tick_next = 1'b1;
      end else begin
        count_next = count_reg + 7'h01;
      end
    end
  end

  // Held in reset between conversions, so no conversion starts on a partial period
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      count_reg <= 7'h00;
      tick_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      tick_reg  <= tick_next;
    end
  end

  assign ctl.tick = tick_reg;
endmodule

// file: src/acc_sync.sv
`timescale 1ns/100ps
module acc_sync (
  input  wire logic sys_clk,
  input  wire logic reset,
  acc_ctl_if.sync   ctl
);
  logic [$bits(ctl.rawIn)-1:0] stage1_reg;
  logic [$bits(ctl.rawIn)-1:0] stage2_reg;

  // Two flops; only the second stage is read
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= ctl.rawIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign ctl.syncOut = stage2_reg;
endmodule

// file: src/acc_top.sv
`timescale 1ns/100ps
// What this block does
// R1: Two-bit reference field picks external pin, supply, 1.1V or 2.56V reference.
// R2: Reference change during a conversion applies only after that conversion completes.
// R3: Alignment bit selects left or right adjusted result, effective at once.
// R4: Channel field change during a conversion applies only after it completes.
// R5: Codes 0-7 single-ended inputs, 11110 bandgap, 11111 ground.
// R6: Codes 01000-01111 differential pairs, gain 10x or 200x by code bit 1.
// R7: Codes 10000-10111 negative input 1, 11000-11101 negative input 2, unity gain.
// R8: Enable bit powers converter; clearing it aborts a running conversion.
// R9: Start bit begins single conversion, or first of free-running conversions.
// R10: First conversion after enabling lasts 25 converter clocks, later ones 13.
// R11: Start bit reads one while converting; writing zero does nothing.
// R12: Auto-trigger starts a conversion on each rising edge of selected trigger.
// R13: Completion flag sets when conversion finishes and result is updated.
// R14: Flag clears on interrupt vector acknowledge or a written one.
// R15: Interrupt request while flag, interrupt enable and global enable are set.
// R16: Software read-modify-write may clear a set flag and lose an interrupt.
// R17: Divider field: codes 0,1 divide by 2, then 4 up to 128.
// R18: After low byte read, result holds until high byte is read.
// R19: Source code 0 is free-running; switching to it never triggers.
// R20: All fields reset to zero: disabled, idle, no flag.
// R21: Free-running restarts each completed conversion while enabled.
module acc_top #(
  parameter int ADDR_WIDTH = 12
) (
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [ADDR_WIDTH-1:0] wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic [6:0]            triggerIn,
  input  wire logic [9:0]            resultIn,
  input  wire logic                  globalIrqEnable,
  input  wire logic                  irqVectorAck,
  output logic                       irqRequest,
  output logic      [1:0]            referenceSelect,
  output logic      [4:0]            channelGainSelect,
  output logic                       converterEnable,
  output logic                       conversionBusy
);
  localparam int RW = acc_pkg::RESULT_WIDTH;
  localparam int TW = acc_pkg::TRIG_COUNT;

  acc_ctl_if #(.SYNC_WIDTH(TW + RW)) ctlBus ();

  acc_prescaler uPrescaler (
    .sys_clk (sys_clk),
    .reset   (reset),
    .ctl     (ctlBus)
  );

  acc_sync uSync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .ctl     (ctlBus)
  );

  acc_pkg::acc_state_e state_reg, state_next;
  logic [1:0]    refSel_reg, refSel_next;
  logic          leftAlign_reg, leftAlign_next;
  logic [4:0]    chanSel_reg, chanSel_next;
  logic          enable_reg, enable_next;
  logic          autoTrig_reg, autoTrig_next;
  logic          doneFlag_reg, doneFlag_next;
  logic          irqEn_reg, irqEn_next;
  logic [2:0]    divSel_reg, divSel_next;
  logic [2:0]    trigSrc_reg, trigSrc_next;
  logic          initPending_reg, initPending_next;
  logic [4:0]    tickCount_reg, tickCount_next;
  logic [1:0]    activeRef_reg, activeRef_next;
  logic [4:0]    activeChan_reg, activeChan_next;
  logic [RW-1:0] result_reg, result_next;
  logic          readLock_reg, readLock_next;
  logic          trigPrev_reg, trigPrev_next;
  logic          ack_reg, ack_next;
  logic [7:0]    datOut_reg, datOut_next;
  logic          irq_reg, irq_next;

  logic          access, wrByte, rdByte;
  logic [7:0]    wIdx, wData;
  logic          wrRef, wrCtl, wrTrig, rdLow, rdHigh;
  logic          trigSel, trigEdge, freeRun, startReq, doneSet, flagClear;
  logic [4:0]    convLen;
  logic [TW-1:0] trigSync;
  logic [RW-1:0] resultSync;
  logic [7:0]    lowByte, highByte, ctlByte;

  assign ctlBus.run    = (state_reg == acc_pkg::ACC_CONV); // Fresh divider phase per run
  assign ctlBus.divSel = divSel_reg; // R17
  assign ctlBus.rawIn  = {triggerIn, resultIn};
  assign trigSync      = ctlBus.syncOut[RW +: TW];
  assign resultSync    = ctlBus.syncOut[RW-1:0];

  // Bus decode; a request is taken once, in the cycle before ack
  always_comb begin
    access = wb_cyc_i && wb_stb_i && !ack_reg;
    wrByte = access && wb_we_i && wb_sel_i[0];
    rdByte = access && !wb_we_i;
    wIdx   = wb_adr_i[9:2];
    wData  = wb_dat_i[7:0];
    wrRef  = wrByte && (wIdx == acc_pkg::IDX_INPUT_REF);
    wrCtl  = wrByte && (wIdx == acc_pkg::IDX_CTRL_STATUS);
    wrTrig = wrByte && (wIdx == acc_pkg::IDX_TRIG_CTRL);
    rdLow  = rdByte && (wIdx == acc_pkg::IDX_RESULT_LOW);
    rdHigh = rdByte && (wIdx == acc_pkg::IDX_RESULT_HIGH);
  end

  // Trigger selection; code 0 maps to a constant low so it never edges
  always_comb begin
    trigSel  = (trigSrc_reg == acc_pkg::TRIG_FREE_RUN) ? 1'b0 : trigSync[trigSrc_reg - 3'h1]; // R19
    trigEdge = autoTrig_reg && trigSel && !trigPrev_reg; // R12
    freeRun  = autoTrig_reg && (trigSrc_reg == acc_pkg::TRIG_FREE_RUN);
    convLen  = initPending_reg ? acc_pkg::FIRST_CONV_CYCLES
                               : acc_pkg::NORMAL_CONV_CYCLES; // R10
  end

  // Result presentation follows the live alignment bit
  always_comb begin
    if (leftAlign_reg) begin // R3
      highByte = result_reg[9:2];
      lowByte  = {result_reg[1:0], 6'h00};
    end else begin
      highByte = {6'h00, result_reg[9:8]};
      lowByte  = result_reg[7:0];
    end
    ctlByte = {enable_reg, (state_reg == acc_pkg::ACC_CONV), autoTrig_reg, doneFlag_reg, // R11
               irqEn_reg, divSel_reg};
  end

  // Software-owned fields
  always_comb begin
    refSel_next    = refSel_reg;
    leftAlign_next = leftAlign_reg;
    chanSel_next   = chanSel_reg;
    enable_next    = enable_reg;
    autoTrig_next  = autoTrig_reg;
    irqEn_next     = irqEn_reg;
    divSel_next    = divSel_reg;
    trigSrc_next   = trigSrc_reg;
    if (wrRef) begin
      refSel_next    = wData[acc_pkg::REF_SEL_LSB +: 2]; // R1
      leftAlign_next = wData[acc_pkg::LEFT_ALIGN_BIT];
      chanSel_next   = wData[acc_pkg::CHAN_SEL_LSB +: 5]; // R5 R6 R7
    end
    if (wrCtl) begin
      enable_next   = wData[acc_pkg::ENABLE_BIT]; // R8
      autoTrig_next = wData[acc_pkg::AUTO_TRIG_BIT];
      irqEn_next    = wData[acc_pkg::IRQ_EN_BIT];
      divSel_next   = wData[acc_pkg::DIV_SEL_LSB +: 3];
    end
    if (wrTrig) begin
      trigSrc_next = wData[acc_pkg::TRIG_SRC_LSB +: 3];
    end
  end

  // Conversion sequencer, counting prescaled converter clock ticks
  always_comb begin
    state_next       = state_reg;
    tickCount_next   = tickCount_reg;
    activeRef_next   = activeRef_reg;
    activeChan_next  = activeChan_reg;
    initPending_next = initPending_reg;
    doneSet          = 1'b0;
    startReq         = (wrCtl && wData[acc_pkg::START_BIT]) || trigEdge; // R9 R11 R12
    if (!enable_next) begin
      state_next       = acc_pkg::ACC_IDLE; // R8
      tickCount_next   = 5'h00;
      initPending_next = 1'b1;
      activeRef_next   = refSel_next; // R2
      activeChan_next  = chanSel_next; // R4
    end else begin
      case (state_reg)
        acc_pkg::ACC_IDLE: begin
          // Selections track software only while nothing converts
          activeRef_next  = refSel_next;
          activeChan_next = chanSel_next;
          if (startReq) begin
            state_next     = acc_pkg::ACC_CONV;
            tickCount_next = 5'h00;
          end
        end
        acc_pkg::ACC_CONV: begin
          if (ctlBus.tick) begin
            if (tickCount_reg == convLen - 5'h01) begin
              doneSet          = 1'b1; // R13
              initPending_next = 1'b0;
              tickCount_next   = 5'h00;
              activeRef_next   = refSel_next; // R2
              activeChan_next  = chanSel_next; // R4
              if (!freeRun) begin
                state_next = acc_pkg::ACC_IDLE; // R21
              end
            end else begin
              tickCount_next = tickCount_reg + 5'h01;
            end
          end
        end
        default: begin
          state_next = acc_pkg::ACC_IDLE;
        end
      endcase
    end
  end

  // Flag, result pairing, trigger history and bus answer
  always_comb begin
    flagClear     = irqVectorAck || (wrCtl && wData[acc_pkg::DONE_FLAG_BIT]); // R14
    doneFlag_next = doneSet || (doneFlag_reg && !flagClear); // R13
    result_next   = (doneSet && !readLock_reg) ? resultSync : result_reg; // R18
    readLock_next = readLock_reg;
    if (rdLow) begin
      readLock_next = 1'b1; // R18
    end
    if (rdHigh) begin
      readLock_next = 1'b0;
    end
    trigPrev_next = trigSel;
    irq_next      = doneFlag_next && irqEn_next && globalIrqEnable; // R15
    ack_next      = wb_cyc_i && wb_stb_i && !ack_reg;
    datOut_next   = 8'h00;
    if (rdByte) begin
      case (wIdx)
        acc_pkg::IDX_RESULT_LOW:  datOut_next = lowByte;
        acc_pkg::IDX_RESULT_HIGH: datOut_next = highByte;
        acc_pkg::IDX_CTRL_STATUS: datOut_next = ctlByte;
        acc_pkg::IDX_TRIG_CTRL:   datOut_next = {5'h00, trigSrc_reg};
        acc_pkg::IDX_INPUT_REF:   datOut_next = {refSel_reg, leftAlign_reg, chanSel_reg};
        default:                  datOut_next = 8'h00;
      endcase
    end
  end

  // All state but initPending_reg resets to zero with the converter off
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg       <= acc_pkg::ACC_IDLE; // R20
      {refSel_reg, leftAlign_reg, chanSel_reg} <= acc_pkg::INPUT_REF_RESET;
      {enable_reg, autoTrig_reg, doneFlag_reg, irqEn_reg} <= 4'h0;
      divSel_reg      <= acc_pkg::CTRL_STATUS_RESET[2:0];
      trigSrc_reg     <= acc_pkg::TRIG_CTRL_RESET[2:0];
      initPending_reg <= 1'b1;
      tickCount_reg   <= 5'h00;
      activeRef_reg   <= 2'h0;
      activeChan_reg  <= 5'h00;
      result_reg      <= '0;
      readLock_reg    <= 1'b0;
      trigPrev_reg    <= 1'b0;
      ack_reg         <= 1'b0;
      datOut_reg      <= 8'h00;
      irq_reg         <= 1'b0;
    end else begin
      state_reg       <= state_next;
      refSel_reg      <= refSel_next;
      leftAlign_reg   <= leftAlign_next;
      chanSel_reg     <= chanSel_next;
      enable_reg      <= enable_next;
      autoTrig_reg    <= autoTrig_next;
      doneFlag_reg    <= doneFlag_next;
      irqEn_reg       <= irqEn_next;
      divSel_reg      <= divSel_next;
      trigSrc_reg     <= trigSrc_next;
      initPending_reg <= initPending_next;
      tickCount_reg   <= tickCount_next;
      activeRef_reg   <= activeRef_next;
      activeChan_reg  <= activeChan_next;
      result_reg      <= result_next;
      readLock_reg    <= readLock_next;
      trigPrev_reg    <= trigPrev_next;
      ack_reg         <= ack_next;
      datOut_reg      <= datOut_next;
      irq_reg         <= irq_next;
    end
  end

  // Outputs come straight from flops
  assign wb_dat_o          = {24'h000000, datOut_reg};
  assign wb_ack_o          = ack_reg;
  assign irqRequest        = irq_reg;
  assign referenceSelect   = activeRef_reg;
  assign channelGainSelect = activeChan_reg;
  assign converterEnable   = enable_reg;
  assign conversionBusy    = (state_reg == acc_pkg::ACC_CONV);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_conv_begins;
    (state_reg == acc_pkg::ACC_IDLE) ##1 (state_reg == acc_pkg::ACC_CONV);
  endsequence

  sequence s_stays_enabled;
    enable_reg [*8];
  endsequence

  a_flag_on_done: assert property (doneSet |=> doneFlag_reg) // R13
    else $error("completion flag not set after conversion end");

  a_flag_write_clear: assert property ( // R14
    (wrCtl && wData[acc_pkg::DONE_FLAG_BIT] && !doneSet) |=> !doneFlag_reg)
    else $error("written one did not clear completion flag");

  a_irq_follows_flag: assert property ( // R15
    (doneFlag_reg && irqEn_reg && globalIrqEnable && !flagClear && !wrCtl) |=> irqRequest)
    else $error("interrupt request missing");

  a_irq_needs_flag: assert property (irqRequest |-> (doneFlag_reg && irqEn_reg)) // R15
    else $error("interrupt request without flag");

  a_disable_aborts: assert property ( // R8
    (wrCtl && !wData[acc_pkg::ENABLE_BIT]) |=> !conversionBusy [*2])
    else $error("conversion survived disable");

  a_conv_min_len: assert property ( // R10
    s_conv_begins ##0 s_stays_enabled |-> conversionBusy)
    else $error("conversion ended too early");

  a_done_count: assert property ( // R10
    doneSet |-> (tickCount_reg == (initPending_reg ? 5'h18 : 5'h0c)))
    else $error("conversion length wrong");

  a_sel_frozen: assert property ( // R2 R4
    (conversionBusy && $past(conversionBusy) && !$past(doneSet))
      |-> ($stable(activeRef_reg) && $stable(activeChan_reg)))
    else $error("selection changed mid conversion");

  a_lock_hold: assert property ((readLock_reg && !rdHigh) |=> $stable(result_reg)) // R18
    else $error("result changed while low byte pending");

  a_trig_starts: assert property ( // R12
    (trigEdge && enable_reg && enable_next && !conversionBusy) |=> conversionBusy)
    else $error("trigger edge did not start conversion");

  a_free_run_zero: assert property ( // R19
    (trigSrc_reg == acc_pkg::TRIG_FREE_RUN) |-> !trigEdge)
    else $error("free-running code produced a trigger");

  a_free_restart: assert property ( // R21
    (doneSet && freeRun && enable_next) |=> conversionBusy)
    else $error("free-running did not restart");

endmodule

// file: tb/acc_tb.sv
`timescale 1ns/100ps
module tb;
  // Bench stimulus and observed outputs
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        wbCyc = 1'b0;
  logic        wbStb = 1'b0;
  logic        wbWe = 1'b0;
  logic [11:0] wbAdr = 12'h000;
  logic [3:0]  wbSel = 4'h0;
  logic [31:0] wbDatIn = 32'h0000_0000;
  logic [31:0] wbDatOut;
  logic        wbAck;
  logic [6:0]  triggerIn = 7'h00;
  logic [9:0]  resultIn = 10'h000;
  logic        globalIrqEnable = 1'b0;
  logic        irqVectorAck = 1'b0;
  logic        irqRequest;
  logic [1:0]  referenceSelect;
  logic [4:0]  channelGainSelect;
  logic        converterEnable;
  logic        conversionBusy;
  int          nMismatch = 0;
  int          compares = 0;
  int          cycleCount = 0;
  int          n;
  int          t0;
  logic [31:0] d;
  logic [4:0]  codes [8] = '{5'h00, 5'h07, 5'h08, 5'h0f, 5'h10, 5'h1d, 5'h1e, 5'h1f};

  localparam logic [11:0] RL = 12'h1e0;
  localparam logic [11:0] RH = 12'h1e4;
  localparam logic [11:0] CS = 12'h1e8;
  localparam logic [11:0] TC = 12'h1ec;
  localparam logic [11:0] IR = 12'h1f0;

  acc_top acc_top_i (
    .sys_clk           (sys_clk),
    .reset             (reset),
    .wb_cyc_i          (wbCyc),
    .wb_stb_i          (wbStb),
    .wb_we_i           (wbWe),
    .wb_adr_i          (wbAdr),
    .wb_sel_i          (wbSel),
    .wb_dat_i          (wbDatIn),
    .wb_dat_o          (wbDatOut),
    .wb_ack_o          (wbAck),
    .triggerIn         (triggerIn),
    .resultIn          (resultIn),
    .globalIrqEnable   (globalIrqEnable),
    .irqVectorAck      (irqVectorAck),
    .irqRequest        (irqRequest),
    .referenceSelect   (referenceSelect),
    .channelGainSelect (channelGainSelect),
    .converterEnable   (converterEnable),
    .conversionBusy    (conversionBusy)
  );

  // 250 MHz system clock
  always #2 sys_clk = ~sys_clk;

  // Cycle ceiling; the divider sweep dominates at about 3.5k cycles
  always @(posedge sys_clk) begin
    cycleCount++;
    if (cycleCount == 20000) begin
      nMismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Checks made %0d, mismatches %0d", compares, nMismatch);
    if (nMismatch == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic cycle; request held until ack is sampled high, only the ceiling ends a hang
  task automatic wb_cycle(input logic we, input logic [11:0] a, input logic [7:0] wd,
                          output logic [31:0] rd);
    @(posedge sys_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= 4'hf;
    wbDatIn <= {24'h000000, wd};
    do begin
      @(posedge sys_clk);
    end while (wbAck !== 1'b1);
    rd = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] wd);
    logic [31:0] x;
    wb_cycle(1'b1, a, wd, x);
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    wb_cycle(1'b0, a, 8'h00, x);
    check(name, x, exp);
  endtask

  // Counts edges until the conversion ends; bounded against a hang
  task automatic wait_idle(output int c);
    c = 0;
    while (conversionBusy !== 1'b0 && c < 4000) begin
      @(posedge sys_clk);
      c++;
    end
  endtask

  task automatic check_len(input string name, input int c, input int ticks, input int dv);
    check(name, {31'h0, (c >= ticks * dv - 2 && c <= ticks * dv + dv + 3)}, 32'h1);
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    // Reset values and an unmapped place
    rd_chk("result_low", RL, 32'h0);
    rd_chk("result_high", RH, 32'h0);
    rd_chk("ctrl_status", CS, 32'h0);
    rd_chk("input_ref", IR, 32'h0);
    rd_chk("unmapped", 12'h100, 32'h0);
    check("enable_out", {31'h0, converterEnable}, 32'h0);
    $display("test reset values done");
    // Every reference code and each channel range boundary except 10111 and 11000, while idle
    for (int i = 0; i < 8; i++) begin
      wr(IR, {i[1:0], 1'b0, codes[i]});
      repeat (3) @(posedge sys_clk);
      check("ref_sel", {30'h0, referenceSelect}, {30'h0, i[1:0]});
      check("chan_sel", {27'h0, channelGainSelect}, {27'h0, codes[i]});
      rd_chk("input_ref_rb", IR, {24'h0, i[1:0], 1'b0, codes[i]});
    end
    $display("test selections done");
    // First conversion: long length, held selections, start reads busy
    wr(IR, 8'h40);
    resultIn <= 10'h270;
    wr(CS, 8'hc0);
    t0 = cycleCount;
    wr(IR, 8'hed);
    wr(CS, 8'h80);
    repeat (2) @(posedge sys_clk);
    check("ref_held", {30'h0, referenceSelect}, 32'h1);
    check("chan_held", {27'h0, channelGainSelect}, 32'h0);
    rd_chk("start_busy", CS, 32'hc0);
    check("enable_on", {31'h0, converterEnable}, 32'h1);
    wait_idle(n);
    check_len("first_len", cycleCount - t0, 25, 2);
    repeat (2) @(posedge sys_clk);
    check("ref_after", {30'h0, referenceSelect}, 32'h3);
    check("chan_after", {27'h0, channelGainSelect}, 32'h0d);
    rd_chk("flag_set", CS, 32'h90);
    rd_chk("left_low", RL, 32'h00);
    rd_chk("left_high", RH, 32'h9c);
    wr(IR, 8'hcd);
    rd_chk("right_low", RL, 32'h70);
    rd_chk("right_high", RH, 32'h02);
    $display("test first conversion done");
    // Flag clearing and interrupt request
    wr(CS, 8'h88);
    rd_chk("flag_w0", CS, 32'h98);
    globalIrqEnable <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("irq_on", {31'h0, irqRequest}, 32'h1);
    globalIrqEnable <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("irq_gmask", {31'h0, irqRequest}, 32'h0);
    globalIrqEnable <= 1'b1;
    irqVectorAck <= 1'b1;
    @(posedge sys_clk);
    irqVectorAck <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("irq_acked", {31'h0, irqRequest}, 32'h0);
    rd_chk("flag_acked", CS, 32'h88);
    $display("test flag and irq done");
    // Divider sweep with normal-length conversions, flag written one each time
    for (int c = 0; c < 8; c++) begin
      wr(CS, {5'b11010, c[2:0]});
      t0 = cycleCount;
      wait_idle(n);
      check_len("div_len", cycleCount - t0, 13, (c < 2) ? 2 : (1 << c));
      rd_chk("div_flag", CS, {24'h0, 5'b10010, c[2:0]});
    end
    wr(CS, 8'h90);
    rd_chk("flag_w1c", CS, 32'h80);
    $display("test divider done");
    // Abort by disable, then the long conversion comes again
    resultIn <= 10'h155;
    wr(CS, 8'hc0);
    repeat (6) @(posedge sys_clk);
    wr(CS, 8'h00);
    repeat (3) @(posedge sys_clk);
    check("abort_busy", {31'h0, conversionBusy}, 32'h0);
    rd_chk("abort_flag", CS, 32'h00);
    wr(CS, 8'hc0);
    t0 = cycleCount;
    wait_idle(n);
    check_len("reinit_len", cycleCount - t0, 25, 2);
    $display("test abort done");
    // Low-byte read locks the result until the high byte is read
    rd_chk("lock_low", RL, 32'h55);
    resultIn <= 10'h2aa;
    wr(CS, 8'hd0);
    wait_idle(n);
    rd_chk("lock_high", RH, 32'h01);
    wr(CS, 8'hd0);
    wait_idle(n);
    rd_chk("new_low", RL, 32'haa);
    rd_chk("new_high", RH, 32'h02);
    $display("test result lock done");
    // Auto trigger on source 1, then switch to free running
    wr(TC, 8'h01);
    rd_chk("trig_src", TC, 32'h1);
    wr(CS, 8'hb0);
    triggerIn <= 7'h01;
    repeat (8) @(posedge sys_clk);
    check("trig_start", {31'h0, conversionBusy}, 32'h1);
    wait_idle(n);
    rd_chk("trig_flag", CS, 32'hb0);
    wr(TC, 8'h00);
    repeat (8) @(posedge sys_clk);
    check("freerun_switch", {31'h0, conversionBusy}, 32'h0);
    wr(CS, 8'hf0);
    repeat (60) @(posedge sys_clk);
    check("freerun_cont", {31'h0, conversionBusy}, 32'h1);
    rd_chk("freerun_flag", CS, 32'hf0);
    wr(CS, 8'h10);
    repeat (3) @(posedge sys_clk);
    check("freerun_stop", {31'h0, conversionBusy}, 32'h0);
    $display("test triggering done");
    give_verdict();
  end
endmodule
